// ---- design/sma_slave.sv ----
// smbus slave with pointer protocol, check byte, timeouts and alert
// assumes a 100 MHz mclk_in, bus clock on bus_clk_in, pads resolved outside
`timescale 1ns/1ps
`include "sma_defines.svh"

module sma_slave #(
   parameter int TMO_CYC = `SMA_TMO_CYC,
   parameter int TMO_W = `SMA_TMO_W
)(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic bus_clk_in,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_out,
   input wire logic [1:0] addr_strap_low_in,
   input wire logic [1:0] addr_strap_high_in,
   input wire logic alert_pin_in,
   output logic alert_pin_out,
   output logic alert_pin_oe_out,
   input wire logic fault_mode_in,
   input wire logic fault_cond_in,
   input wire logic status_set_in,
   input wire logic [7:0] reg_rdata_in,
   output sma_pkg::sma_reg_req_t reg_req_out,
   output logic [7:0] tmo_ctrl_out,
   output logic [6:0] own_addr_out
);

   // ****************************************************
   // elaboration checks
   // ****************************************************
   if (TMO_CYC < 1 || TMO_W > 30 || TMO_CYC >= (1 << TMO_W)) begin : g_bad_tmo
      $error("timeout count does not fit its counter");
   end

   // crc-8 over one byte, msb first
   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `SMA_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // ****************************************************
   // link domain: bit sampled on the bus clock rise
   // ****************************************************
   logic link_bit_ff;

   // data flop only, read in mclk after the clock edge is seen
   always_ff @(posedge bus_clk_in) begin
      link_bit_ff <= serial_data_pin_in;
   end

   // ****************************************************
   // synchronisers into mclk
   // ****************************************************
   logic scl_s1_ff, scl_s2_ff, scl_s3_ff, sda_s1_ff, sda_s2_ff, sda_s3_ff;
   logic lbit_s1_ff, lbit_s2_ff, rise_d_ff;
   logic [3:0] strap_s1_ff, strap_s2_ff;

   // two flops before any logic, third only for edges
   always_ff @(posedge mclk_in) begin
      scl_s1_ff <= bus_clk_in;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= serial_data_pin_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
      lbit_s1_ff <= link_bit_ff;
      lbit_s2_ff <= lbit_s1_ff;
      strap_s1_ff <= {addr_strap_high_in, addr_strap_low_in};
      strap_s2_ff <= strap_s1_ff;
      rise_d_ff <= rstn_in & scl_s2_ff & ~scl_s3_ff;
   end

   // bus events
   wire scl_fall = ~scl_s2_ff & scl_s3_ff;
   wire scl_hi = scl_s2_ff & scl_s3_ff;
   wire start_det = scl_hi & ~sda_s2_ff & sda_s3_ff;
   wire stop_det = scl_hi & sda_s2_ff & ~sda_s3_ff;
   wire rx_bit = lbit_s2_ff;

   // ****************************************************
   // address straps
   // ****************************************************
   logic strap_done_ff;
   logic [6:0] own_addr_ff;
   wire [1:0] strap_hi = strap_s2_ff[3:2];
   wire [1:0] strap_lo = strap_s2_ff[1:0];
   wire [6:0] strap_base = (strap_hi == `SMA_STRAP_LOW) ? `SMA_BASE_STRAP_LOW :
                           (strap_hi == `SMA_STRAP_HIGH) ? `SMA_BASE_STRAP_HIGH :
                           `SMA_BASE_STRAP_OPEN;
   wire [6:0] strap_ofs = (strap_lo == `SMA_STRAP_LOW) ? 7'h00 :
                          (strap_lo == `SMA_STRAP_HIGH) ? 7'h02 : 7'h01;

   // caught once, first edge after reset release
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         strap_done_ff <= 1'b0;
         own_addr_ff <= 7'h00;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         own_addr_ff <= strap_base + strap_ofs;
      end
   end

   // ****************************************************
   // engine state
   // ****************************************************
   sma_pkg::sma_state_t state_ff, nxt_state;
   logic [2:0] cnt_ff, nxt_cnt, idx_ff, nxt_idx;
   logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr, wdat_ff, nxt_wdat, crc_ff, nxt_crc;
   logic dir_ff, nxt_dir, ara_ff, nxt_ara, ack_ff, nxt_ack, lost_ff, nxt_lost;
   logic oe_ff, nxt_oe, pend_ff, nxt_pend;
   logic commit, rd_pulse, ara_done, alert_ff, wr_ff, rd_ff;
   logic [7:0] tmo_reg_ff;
   logic [TMO_W-1:0] tmo_cnt_ff;

   // byte views
   wire [7:0] rx_byte = {sh_ff[6:0], rx_bit};
   wire [7:0] crc_rx = crc8_step(crc_ff, rx_byte);
   wire own_hit = (rx_byte[7:1] == own_addr_ff);
   wire ara_hit = (rx_byte[7:1] == `SMA_ARA_ADDR) & rx_byte[0] & alert_ff;
   wire [7:0] rdata_sel = (ptr_ff == `SMA_REG_TMO_ADDR) ? tmo_reg_ff : reg_rdata_in;
   wire [7:0] first_tx = ara_ff ? {own_addr_ff, 1'b1} : rdata_sel;
   wire [7:0] tx_byte = (idx_ff == 3'h1) ? first_tx :
                        (idx_ff == 3'h2) ? crc_ff : 8'hff;
   wire tmo_hit = (tmo_cnt_ff == TMO_W'(TMO_CYC - 1));

   // ****************************************************
   // protocol engine, next state
   // ****************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_idx = idx_ff;
      nxt_dir = dir_ff;
      nxt_ara = ara_ff;
      nxt_ack = ack_ff;
      nxt_lost = lost_ff;
      nxt_oe = oe_ff;
      nxt_ptr = ptr_ff;
      nxt_wdat = wdat_ff;
      nxt_pend = pend_ff;
      nxt_crc = crc_ff;
      commit = 1'b0;
      rd_pulse = 1'b0;
      ara_done = 1'b0;
      if (tmo_hit) begin
         nxt_state = sma_pkg::st_idle;
         nxt_oe = 1'b0;
         nxt_pend = 1'b0;
      end else if (start_det || stop_det) begin
         commit = pend_ff;
         nxt_pend = 1'b0;
         nxt_oe = 1'b0;
         nxt_cnt = 3'h0;
         nxt_idx = 3'h0;
         nxt_crc = 8'h00;
         nxt_state = start_det ? sma_pkg::st_rx : sma_pkg::st_idle;
      end else begin
         case (state_ff)
            sma_pkg::st_rx: begin
               if (rise_d_ff) begin
                  nxt_sh = rx_byte;
                  nxt_cnt = cnt_ff + 3'h1;
                  if (cnt_ff == 3'h7) begin
                     nxt_crc = crc_rx;
                     nxt_idx = idx_ff + 3'h1;
                     nxt_ack = 1'b1;
                     nxt_state = sma_pkg::st_rxack;
                     case (idx_ff)
                        3'h0: begin
                           nxt_dir = rx_byte[0];
                           nxt_ara = ara_hit;
                           if (!own_hit && !ara_hit) begin
                              nxt_state = sma_pkg::st_idle;
                           end
                        end
                        3'h1: nxt_ptr = rx_byte;
                        3'h2: begin
                           nxt_wdat = rx_byte;
                           nxt_pend = 1'b1;
                        end
                        3'h3: begin
                           commit = pend_ff & (crc_rx == 8'h00);
                           nxt_pend = 1'b0;
                        end
                        default: nxt_state = sma_pkg::st_idle;
                     endcase
                  end
               end
            end
            sma_pkg::st_rxack: begin
               if (scl_fall) begin
                  nxt_oe = ack_ff;
                  nxt_state = sma_pkg::st_ackh;
               end
            end
            sma_pkg::st_ackh: begin
               if (scl_fall) begin
                  nxt_cnt = 3'h0;
                  nxt_lost = 1'b0;
                  if (dir_ff) begin
                     nxt_sh = tx_byte;
                     nxt_oe = ~tx_byte[7];
                     nxt_idx = idx_ff + 3'h1;
                     rd_pulse = (idx_ff == 3'h1) & ~ara_ff;
                     if (idx_ff == 3'h1) begin
                        nxt_crc = crc8_step(crc_ff, tx_byte);
                     end
                     nxt_state = sma_pkg::st_tx;
                  end else begin
                     nxt_oe = 1'b0;
                     nxt_state = sma_pkg::st_rx;
                  end
               end
            end
            sma_pkg::st_tx: begin
               if (scl_fall) begin
                  nxt_oe = ~sh_ff[7] & ~lost_ff;
               end else if (rise_d_ff) begin
                  nxt_sh = {sh_ff[6:0], 1'b1};
                  nxt_cnt = cnt_ff + 3'h1;
                  if (sh_ff[7] && !rx_bit) begin
                     nxt_lost = 1'b1;
                     nxt_oe = 1'b0;
                     nxt_state = sma_pkg::st_idle;
                  end else if (cnt_ff == 3'h7) begin
                     nxt_state = sma_pkg::st_txack;
                     ara_done = ara_ff & (idx_ff == 3'h2);
                  end
               end
            end
            sma_pkg::st_txack: begin
               if (scl_fall) begin
                  nxt_oe = 1'b0;
               end else if (rise_d_ff) begin
                  nxt_state = rx_bit ? sma_pkg::st_idle : sma_pkg::st_ackh;
               end
            end
            sma_pkg::st_idle: begin
               nxt_oe = 1'b0;
            end
            default: begin
               nxt_state = sma_pkg::st_idle;
               nxt_oe = 1'b0;
            end
         endcase
      end
   end

   // engine registers
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         state_ff <= sma_pkg::st_idle;
         cnt_ff <= 3'h0;
         idx_ff <= 3'h0;
         oe_ff <= 1'b0;
         pend_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         idx_ff <= nxt_idx;
         oe_ff <= nxt_oe;
         pend_ff <= nxt_pend;
      end
   end

   // transfer data registers
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         sh_ff <= 8'h00;
         dir_ff <= 1'b0;
         ara_ff <= 1'b0;
         ack_ff <= 1'b0;
         lost_ff <= 1'b0;
         crc_ff <= 8'h00;
      end else begin
         sh_ff <= nxt_sh;
         dir_ff <= nxt_dir;
         ara_ff <= nxt_ara;
         ack_ff <= nxt_ack;
         lost_ff <= nxt_lost;
         crc_ff <= nxt_crc;
      end
   end

   // pointer and pending write data
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         ptr_ff <= 8'h00;
         wdat_ff <= 8'h00;
      end else begin
         ptr_ff <= nxt_ptr;
         wdat_ff <= nxt_wdat;
      end
   end

   // ****************************************************
   // register side effects
   // ****************************************************
   wire commit_tmo = commit & (ptr_ff == `SMA_REG_TMO_ADDR);

   // timeout control register and outside strobes
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         tmo_reg_ff <= `SMA_REG_TMO_RESET;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
      end else begin
         if (commit_tmo) begin
            tmo_reg_ff <= wdat_ff;
         end
         wr_ff <= commit & ~commit_tmo;
         rd_ff <= rd_pulse;
      end
   end

   // ****************************************************
   // bus timeout
   // ****************************************************
   wire tmo_scl = tmo_reg_ff[`SMA_TMO_SCL_BIT] & ~scl_s2_ff;
   wire tmo_sda = tmo_reg_ff[`SMA_TMO_SDA_BIT] & ~sda_s2_ff;
   wire tmo_run = (state_ff != sma_pkg::st_idle) & (tmo_scl | tmo_sda);

   // counts while an enabled line is low outside idle, cleared once no enabled line is low
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || !tmo_run || tmo_hit) begin
         tmo_cnt_ff <= '0;
      end else begin
         tmo_cnt_ff <= tmo_cnt_ff + TMO_W'(1);
      end
   end

   // ****************************************************
   // fault output
   // ****************************************************
   wire alert_set = fault_mode_in & fault_cond_in;
   wire alert_clr = ara_done & ~fault_cond_in & ~status_set_in;

   // set wins over the release
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         alert_ff <= 1'b0;
      end else if (alert_set) begin
         alert_ff <= 1'b1;
      end else if (alert_clr || !fault_mode_in) begin
         alert_ff <= 1'b0;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign serial_data_pin_out = 1'b0;
   assign serial_data_pin_oe_out = oe_ff;
   assign alert_pin_out = 1'b0;
   assign alert_pin_oe_out = alert_ff;
   assign reg_req_out.addr = ptr_ff;
   assign reg_req_out.wdata = wdat_ff;
   assign reg_req_out.wr = wr_ff;
   assign reg_req_out.rd = rd_ff;
   assign tmo_ctrl_out = tmo_reg_ff;
   assign own_addr_out = own_addr_ff;

endmodule

// ---- inc/sma_defines.svh ----
// constants of the smbus slave and alert block
// assumes inclusion by the slave module only, by bare name
`ifndef SMA_DEFINES_SVH
`define SMA_DEFINES_SVH

// ****************************************************
// register map
// ****************************************************
`define SMA_REG_TMO_ADDR 8'h22
`define SMA_REG_TMO_RESET 8'h01
`define SMA_TMO_SCL_BIT 7
`define SMA_TMO_SDA_BIT 6

// ****************************************************
// addresses
// ****************************************************
`define SMA_ARA_ADDR 7'h0c
`define SMA_BASE_STRAP_LOW 7'h18
`define SMA_BASE_STRAP_OPEN 7'h29
`define SMA_BASE_STRAP_HIGH 7'h4c
`define SMA_STRAP_LOW 2'h0
`define SMA_STRAP_OPEN 2'h1
`define SMA_STRAP_HIGH 2'h2

// ****************************************************
// check byte and timing
// ****************************************************
`define SMA_CRC_POLY 8'h07
`define SMA_MCLK_MHZ 100
`define SMA_TMO_US 25000
`define SMA_TMO_CYC (`SMA_MCLK_MHZ * `SMA_TMO_US)
`define SMA_TMO_W 22

`endif

// ---- inc/sma_pkg.sv ----
// types of the smbus slave and alert block
// assumes nothing beyond a systemverilog compiler
package sma_pkg;

   // ****************************************************
   // protocol engine states, one-hot
   // ****************************************************
   typedef enum logic [5:0] {
      st_idle  = 6'h01,
      st_rx    = 6'h02,
      st_rxack = 6'h04,
      st_ackh  = 6'h08,
      st_tx    = 6'h10,
      st_txack = 6'h20
   } sma_state_t;

   // ****************************************************
   // request to the register file outside
   // ****************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sma_reg_req_t;

endpackage

// ---- verif/sma_host_model.sv ----
// behavioural smbus host, makes the bus clock within frames only
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module sma_host_model (
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_in
);
   // ****************************************
   // bus idle and frame tasks
   // ****************************************
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // start or repeated start, odd delay shifts phase
   task automatic start();
      sda_low_out = 1'b0;
      #23;
      scl_out = 1'b1;
      #40;
      sda_low_out = 1'b1;
      #40;
      scl_out = 1'b0;
      #20;
   endtask
   // one clock, data set while low, sampled mid high
   task automatic bit_cyc(input logic d, output logic s);
      sda_low_out = ~d;
      #20;
      scl_out = 1'b1;
      #20;
      s = sda_in;
      #20;
      scl_out = 1'b0;
      #20;
   endtask
   // eight bits msb first, then the ninth clock
   task automatic xfer(input logic [7:0] d, input logic a_drv, output logic [7:0] g,
      output logic a_seen);
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(d[i], g[i]);
      end
      bit_cyc(a_drv, a_seen);
   endtask
   // stop, data low then released with clock high
   task automatic stop();
      sda_low_out = 1'b1;
      #20;
      scl_out = 1'b1;
      #40;
      sda_low_out = 1'b0;
      #40;
   endtask
endmodule

// ---- verif/sma_slave_asserts.sv ----
// port checks of the smbus slave
// assumes a bind onto sma_slave, figures in mclk_in cycles
`timescale 1ns/1ps
module sma_slave_asserts #(
   parameter int TMO_CYC = 200
)(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic bus_clk_in,
   input wire logic serial_data_pin_in,
   input wire logic serial_data_pin_oe_out,
   input wire logic [1:0] addr_strap_low_in,
   input wire logic [1:0] addr_strap_high_in,
   input wire logic alert_pin_oe_out,
   input wire logic fault_mode_in,
   input wire logic fault_cond_in,
   input wire logic status_set_in,
   input wire sma_pkg::sma_reg_req_t reg_req_out,
   input wire logic [7:0] tmo_ctrl_out,
   input wire logic [6:0] own_addr_out
);
   // ****************************************
   // helper logic
   // ****************************************
   int scl_lo_cnt;
   int sda_lo_cnt;
   // strap levels to address, code 3 reads as open
   wire [6:0] base_w = (addr_strap_high_in == 2'h0) ? 7'h18 :
      (addr_strap_high_in == 2'h2) ? 7'h4c : 7'h29;
   wire [6:0] offs_w = (addr_strap_low_in == 2'h0) ? 7'h00 :
      (addr_strap_low_in == 2'h2) ? 7'h02 : 7'h01;
   wire [6:0] strap_addr_w = base_w + offs_w;
   // saturating low-time counter of the bus clock
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || bus_clk_in) begin
         scl_lo_cnt <= 0;
      end else if (scl_lo_cnt < TMO_CYC + 16) begin
         scl_lo_cnt <= scl_lo_cnt + 1;
      end
   end
   // same for the data line
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || serial_data_pin_in) begin
         sda_lo_cnt <= 0;
      end else if (sda_lo_cnt < TMO_CYC + 16) begin
         sda_lo_cnt <= sda_lo_cnt + 1;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   a_tmo_default: assert property ($rose(rstn_in) |-> tmo_ctrl_out == 8'h01)
      else $error("timeout control not at reset value");
   a_scl_timeout: assert property (tmo_ctrl_out[7] && scl_lo_cnt >= TMO_CYC + 8 |-> !serial_data_pin_oe_out)
      else $error("data held after clock timeout");
   a_sda_timeout: assert property (tmo_ctrl_out[6] && sda_lo_cnt >= TMO_CYC + 8 |-> !serial_data_pin_oe_out)
      else $error("data held after data timeout");
   a_strap_latch: assert property ($past(rstn_in) && !$past(rstn_in, 2) |-> own_addr_out == $past(strap_addr_w))
      else $error("address not taken from straps");
   a_strap_hold: assert property ($changed(own_addr_out) |-> !$past(rstn_in, 2))
      else $error("address moved after start-up");
   a_oe_clock_low: assert property ($changed(serial_data_pin_oe_out) |-> !$past(bus_clk_in))
      else $error("data changed while clock high");
   a_oe_stands: assert property ($rose(serial_data_pin_oe_out) |=> serial_data_pin_oe_out [*6])
      else $error("data pull too short");
   a_wr_outside: assert property (reg_req_out.wr |-> reg_req_out.addr != 8'h22)
      else $error("strobe for internal register");
   a_alert_set: assert property (fault_mode_in && fault_cond_in |-> ##[1:2] alert_pin_oe_out)
      else $error("fault not signalled");
   a_alert_release: assert property ($fell(alert_pin_oe_out) |->
      !$past(fault_mode_in) || (!$past(fault_cond_in) && !$past(status_set_in)))
      else $error("fault released too early");
   c_write: cover property (reg_req_out.wr);
   c_read: cover property (reg_req_out.rd);
   c_release: cover property ($fell(alert_pin_oe_out));
   c_timeout: cover property (tmo_ctrl_out[7] && scl_lo_cnt >= TMO_CYC + 8);
endmodule

// ---- verif/sma_slave_tb_top.sv ----
// self-checking bench of the smbus slave against a host model
// assumes sma_pkg compiled first and the checker file present
`timescale 1ns/1ps
module sma_slave_tb_top;
   localparam int TMO_CYC = 200;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [1:0] strap_lo = 2'h0;
   logic [1:0] strap_hi = 2'h0;
   logic fault_mode = 1'b0;
   logic fault_cond = 1'b0;
   logic status_set = 1'b0;
   logic [7:0] rdata = 8'h00;
   wire scl;
   wire sda_low;
   wire sda_oe;
   wire alert_oe;
   wire sda_w;
   wire sda_do;
   wire alert_do;
   sma_pkg::sma_reg_req_t req;
   logic [7:0] tmo;
   logic [6:0] own;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_rd = 0;
   logic [7:0] m_ptr = 8'h00;
   logic [31:0] seed = 32'h9;
   logic [7:0] m_tmo = 8'h01;
   logic [6:0] base [3] = '{7'h18, 7'h29, 7'h4c};
   logic [15:0] exp_q[$];
   // ****************************************
   // harness
   // ****************************************
   always #5 mclk_in = ~mclk_in;
   assign sda_w = ~(sda_low | sda_oe);
   sma_slave #(.TMO_CYC(TMO_CYC), .TMO_W(22)) u_dut (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .bus_clk_in(scl),
      .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_do), .serial_data_pin_oe_out(sda_oe),
      .addr_strap_low_in(strap_lo), .addr_strap_high_in(strap_hi),
      .alert_pin_in(~alert_oe), .alert_pin_out(alert_do), .alert_pin_oe_out(alert_oe),
      .fault_mode_in(fault_mode), .fault_cond_in(fault_cond), .status_set_in(status_set),
      .reg_rdata_in(rdata), .reg_req_out(req), .tmo_ctrl_out(tmo), .own_addr_out(own));
   sma_host_model u_h (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_w));
   // outside registers read back as pointer xor a5
   always @(posedge mclk_in) rdata <= req.addr ^ 8'ha5;
   // each write strobe against the oldest expected write
   always @(posedge mclk_in) begin
      if (req.wr === 1'b1) begin
         chk({req.addr, req.wdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx);
      end
      if (req.rd === 1'b1) begin
         n_rd++;
         chk(req.addr, m_ptr);
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // one byte into the check value, poly 0x07
   function automatic logic [7:0] crc_add(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
      end
      return r;
   endfunction
   // ****************************************
   // transfers
   // ****************************************
   task automatic do_write(input logic [7:0] p, input logic [7:0] d, input int n,
      input logic bad);
      logic [7:0] g;
      logic a;
      logic [7:0] c;
      c = crc_add(crc_add(crc_add(8'h00, {own, 1'b0}), p), d);
      u_h.start();
      u_h.xfer({own, 1'b0}, 1'b1, g, a);
      chk(a, 1'b0);
      u_h.xfer(p, 1'b1, g, a);
      m_ptr = p;
      chk(a, 1'b0);
      if (n > 1) begin
         if (!bad && p == 8'h22) begin
            m_tmo = d;
         end else if (!bad) begin
            exp_q.push_back({p, d});
         end
         u_h.xfer(d, 1'b1, g, a);
         chk(a, 1'b0);
      end
      if (n > 2) begin
         u_h.xfer(c ^ {7'h00, bad}, 1'b1, g, a);
         chk(a, 1'b0);
      end
      if (n > 3) begin
         u_h.xfer(c, 1'b1, g, a);
         chk(a, 1'b1);
      end
      u_h.stop();
      repeat (6) @(posedge mclk_in);
      chk(tmo, m_tmo);
   endtask
   task automatic do_read(input logic [6:0] a7, input logic [7:0] mask, input logic pec,
      input logic ack, input logic [7:0] e);
      logic [7:0] g;
      logic a;
      u_h.start();
      u_h.xfer({a7, 1'b1}, 1'b1, g, a);
      chk(a, !ack);
      if (ack) begin
         u_h.xfer(~mask, !pec, g, a);
         chk(g, e);
         if (pec) begin
            u_h.xfer(8'hff, 1'b1, g, a);
            chk(g, crc_add(crc_add(8'h00, {a7, 1'b1}), e));
         end
      end
      u_h.stop();
   endtask
   // address then bus clock held low, then finish
   task automatic hold_low(input logic e);
      logic s;
      u_h.start();
      for (int i = 7; i >= 0; i--) begin
         u_h.bit_cyc(i > 0 ? own[i - 1] : 1'b0, s);
      end
      #3000;
      chk(sda_oe, e);
      u_h.bit_cyc(1'b1, s);
      u_h.stop();
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      logic [7:0] p;
      repeat (2) @(posedge mclk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      chk(tmo, 8'h01);
      for (int i = 0; i < 9; i++) begin
         strap_hi <= 2'(i / 3);
         strap_lo <= 2'(i % 3);
         rstn_in <= 1'b0;
         repeat (3) @(posedge mclk_in);
         rstn_in <= 1'b1;
         repeat (3) @(posedge mclk_in);
         chk(own, base[i / 3] + 7'(i % 3));
      end
      strap_hi <= 2'(rnd());
      strap_lo <= 2'(rnd());
      hold_low(1'b1);
      do_write(8'h22, 8'hc1, 2, 1'b0);
      hold_low(1'b0);
      for (int i = 1; i <= 4; i++) begin
         p = 8'(rnd());
         p = (p == 8'h22) ? 8'h23 : p;
         do_write(p, 8'(rnd()), i, 1'b0);
         do_read(own, 8'h00, i[0], 1'b1, p ^ 8'ha5);
         do_read(own, 8'h00, 1'b0, 1'b1, p ^ 8'ha5);
      end
      do_write(8'h31, 8'(rnd()), 3, 1'b1);
      do_read(7'h5a, 8'h00, 1'b0, 1'b0, 8'h00);
      fault_mode <= 1'b1;
      fault_cond <= 1'b1;
      status_set <= 1'b1;
      repeat (3) @(posedge mclk_in);
      chk(alert_oe, 1'b1);
      for (int i = 0; i < 4; i++) begin
         fault_cond <= (i < 2);
         status_set <= (i < 3);
         repeat (2) @(posedge mclk_in);
         do_read(7'h0c, (i == 0) ? 8'h80 : 8'h00, i == 1, 1'b1,
            (i == 0) ? 8'h7f : {own, 1'b1});
         repeat (4) @(posedge mclk_in);
         chk(alert_oe, i < 3);
      end
      do_read(7'h0c, 8'h00, 1'b0, 1'b0, 8'h00);
      chk(own, 7'h4e);
      chk(16'(exp_q.size()), 16'h0000);
      chk(16'(n_rd), 16'h0008);
      chk({sda_do, alert_do}, 2'h0);
      report_and_stop();
   end
   // run limit
   initial begin
      repeat (100000) @(posedge mclk_in);
      n_mismatch++;
      report_and_stop();
   end
endmodule
bind sma_slave sma_slave_asserts #(.TMO_CYC(TMO_CYC)) u_chk (
   .mclk_in(mclk_in), .rstn_in(rstn_in), .bus_clk_in(bus_clk_in),
   .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_oe_out(serial_data_pin_oe_out),
   .addr_strap_low_in(addr_strap_low_in), .addr_strap_high_in(addr_strap_high_in),
   .alert_pin_oe_out(alert_pin_oe_out), .fault_mode_in(fault_mode_in),
   .fault_cond_in(fault_cond_in), .status_set_in(status_set_in), .reg_req_out(reg_req_out),
   .tmo_ctrl_out(tmo_ctrl_out), .own_addr_out(own_addr_out));
